// ===== nsh_kpi_defs.svh
`ifndef NSH_KPI_DEFS_SVH
`define NSH_KPI_DEFS_SVH
`define MD_TYPE_KPI 8'h02
`define MD_CLASS_KPI 16'h0210
`define TYPE_TS_DETECT 7'h01
`define KIND_TS 8'h01
`define RPT_TS_EXT 8'h02
`define RPT_QOS_EXT 8'h03
`define SYNC_LOCKED 2'h0
`define SYNC_HOLD 2'h1
`define SYNC_FREE 2'h2
`define SYNC_LOST 2'h3
`define BASE_LEN 6'h07
`define CTX_LEN 7'h04
`define W_BASE 3'h0
`define W_PATH 3'h1
`define W_CTX 3'h2
`define W_FLOW 3'h3
`define W_THR 3'h4
`define W_TSH 3'h5
`define W_TSL 3'h6
`define F_OAM 29
`define F_BLEN 21:16
`define F_MDTYPE 15:8
`define F_NP 7:0
`define F_SPI 31:8
`define F_SSEL 23:0
`define F_SI 7:0
`define F_CLASS 31:16
`define F_CRIT 15
`define F_TYPE 14:8
`define F_TYPE_MSB 14
`define F_CLEN 6:0
`define F_KIND 31:24
`define F_VSI 23:16
`define F_FLOW 15:0
`define F_VIOL 31
`define F_THR 30:0
`define A_CTRL 5'h00
`define A_SEL_SPI 5'h04
`define A_SEL_FLOW 5'h08
`define A_THRESH 5'h0C
`define A_LIM_PKTS 5'h10
`define A_LIM_TIME 5'h14
`define A_STATUS 5'h18
`define A_COUNT 5'h1C
`define C_ROLE 0
`define C_THR_EN 1
`define C_WHERE 3:2
`define C_START 4
`define C_KIND 15:8
`define C_TSI 23:16
`define S_WILD 31
`define S_REFUSE 1
`define WH_ING 2'h0
`define WH_EGR 2'h1
`define WH_BOTH 2'h2
`define WH_SPEC 2'h3
`endif

// ===== nsh_kpi_pkg.sv
package nsh_kpi_pkg;
    typedef logic [31:0] word_t;
    typedef logic [1:0] sync_t;
    typedef enum {ST_IDLE, ST_COLLECT, ST_DECIDE, ST_EMIT, ST_PASS} fsm_t;
endpackage

// ===== nsh_cfg_if.sv
`timescale 1ns/1ps
interface nsh_cfg_if;
    import nsh_kpi_pkg::*;
    word_t ctrl, sel_spi, sel_flow, thresh, lim_pkts, lim_time;
    logic start, clr_refuse;
    logic active, refuse;
    sync_t sync;
    logic [15:0] stamp_cnt, viol_cnt;
    modport regs(output ctrl, sel_spi, sel_flow, thresh, lim_pkts, lim_time,
        start, clr_refuse, input active, refuse, sync, stamp_cnt, viol_cnt);
    modport core(input ctrl, sel_spi, sel_flow, thresh, lim_pkts, lim_time,
        start, clr_refuse, output active, refuse, sync, stamp_cnt, viol_cnt);
endinterface

// ===== nsh_kpi_regs.sv
`timescale 1ns/1ps
`include "nsh_kpi_defs.svh"
module nsh_kpi_regs (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire nsh_kpi_pkg::word_t avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output nsh_kpi_pkg::word_t avs_readdata,
    output logic avs_waitrequest,
    nsh_cfg_if.regs cfg
);
    import nsh_kpi_pkg::*;

    // Merges written byte lanes into a stored word.
    function automatic word_t be_merge(word_t old, word_t nw,
                                       logic [3:0] be);
        word_t r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    word_t ctrl_q, spi_q, flow_q, thr_q, lpk_q, ltm_q, rdata_q;
    logic ack_q;

    // Every access takes two cycles; a write is seen for a full cycle
    // before it acts, while a read samples its data in the first cycle.
    wire req = avs_read | avs_write;
    wire wr_ok = avs_write & ack_q;
    wire rd_go = avs_read & !ack_q;
    wire wr_ctrl = wr_ok & (avs_address == `A_CTRL);
    wire word_t ctrl_w = be_merge(ctrl_q, avs_writedata, avs_byteenable);
    wire word_t status_w = {28'h0, cfg.sync, cfg.refuse, cfg.active};
    wire word_t count_w = {cfg.viol_cnt, cfg.stamp_cnt};
    wire word_t rd_mux =
        (avs_address == `A_CTRL) ? ctrl_q :
        (avs_address == `A_SEL_SPI) ? spi_q :
        (avs_address == `A_SEL_FLOW) ? flow_q :
        (avs_address == `A_THRESH) ? thr_q :
        (avs_address == `A_LIM_PKTS) ? lpk_q :
        (avs_address == `A_LIM_TIME) ? ltm_q :
        (avs_address == `A_STATUS) ? status_w :
        (avs_address == `A_COUNT) ? count_w : 32'h0;

    assign avs_waitrequest = req & !ack_q;
    assign avs_readdata = rdata_q;
    assign cfg.start = wr_ctrl & avs_byteenable[0]
                       & avs_writedata[`C_START];
    assign cfg.clr_refuse = wr_ok & (avs_address == `A_STATUS)
                            & avs_byteenable[0] & avs_writedata[`S_REFUSE];
    assign cfg.ctrl = ctrl_q;
    assign cfg.sel_spi = spi_q;
    assign cfg.sel_flow = flow_q;
    assign cfg.thresh = thr_q;
    assign cfg.lim_pkts = lpk_q;
    assign cfg.lim_time = ltm_q;

    always_ff @(posedge ref_clk) begin
        ack_q <= srst ? 1'b0 : (req & !ack_q);
        rdata_q <= srst ? 32'h0 : (rd_go ? rd_mux : rdata_q);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_q <= 32'h0;
            spi_q <= 32'h0;
            flow_q <= 32'h0;
            thr_q <= 32'h0;
            lpk_q <= 32'h0;
            ltm_q <= 32'h0;
        end else if (wr_ok) begin
            case (avs_address)
                `A_CTRL: ctrl_q <= ctrl_w & ~(32'h1 << `C_START);
                `A_SEL_SPI: spi_q <= be_merge(spi_q, avs_writedata,
                                              avs_byteenable);
                `A_SEL_FLOW: flow_q <= be_merge(flow_q, avs_writedata,
                                                avs_byteenable);
                `A_THRESH: thr_q <= be_merge(thr_q, avs_writedata,
                                             avs_byteenable);
                `A_LIM_PKTS: lpk_q <= be_merge(lpk_q, avs_writedata,
                                               avs_byteenable);
                `A_LIM_TIME: ltm_q <= be_merge(ltm_q, avs_writedata,
                                               avs_byteenable);
                default: ;
            endcase
        end
    end

    a_bus_answer: assert property (@(posedge ref_clk) disable iff (srst)
        req && !ack_q |=> !avs_waitrequest)
        else $error("bus answer not given in the second cycle");
endmodule

// ===== nsh_kpi_stamp_detector.sv
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "nsh_kpi_defs.svh"
module nsh_kpi_stamp_detector (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire nsh_kpi_pkg::word_t avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output nsh_kpi_pkg::word_t avs_readdata,
    output logic avs_waitrequest,
    input wire logic in_valid,
    output logic in_ready,
    input wire nsh_kpi_pkg::word_t in_data,
    input wire logic in_sop,
    input wire logic in_eop,
    input wire logic [23:0] cls_spi,
    input wire logic [7:0] cls_si,
    input wire logic [15:0] cls_flow,
    input wire logic [7:0] cls_next_proto,
    input wire logic [63:0] ts_now,
    input wire nsh_kpi_pkg::sync_t sync_state,
    output logic out_valid,
    input wire logic out_ready,
    output nsh_kpi_pkg::word_t out_data,
    output logic out_sop,
    output logic out_eop,
    output logic rpt_valid,
    input wire logic rpt_ready,
    output nsh_kpi_pkg::word_t rpt_data,
    output logic rpt_last,
    output logic [7:0] rpt_kind,
    output logic [3:0] rpt_flags
);
    import nsh_kpi_pkg::*;

    nsh_cfg_if cfg ();

    nsh_kpi_regs u_regs (
        .ref_clk(ref_clk),
        .srst(srst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .cfg(cfg.regs)
    );

    ////////////////////////////////////////////////////////////////////////
    fsm_t st_q;
    word_t hdr_q [7];
    logic [2:0] idx_q;
    logic role_q, viol_q, hdr_sent_q, proc_q;
    logic [63:0] ts_loc_q;
    sync_t sy1_q, sy2_q, sy3_q, sync_q;
    logic active_q, refuse_q;
    logic [31:0] pkts_q, time_q;
    logic [15:0] viol_cnt_q;
    logic out_valid_q, out_sop_q, out_eop_q, out_hw_q;
    logic [2:0] out_w_q;
    word_t out_data_q, rpt_data_q;
    logic rpt_valid_q, rpt_last_q;
    logic [7:0] rpt_kind_q;
    logic [3:0] rpt_flags_q;

    // Sync status is a pin; it counts once stages two and three agree.
    always_ff @(posedge ref_clk) begin
        sy1_q <= srst ? `SYNC_LOST : sync_state;
        sy2_q <= srst ? `SYNC_LOST : sy1_q;
        sy3_q <= srst ? `SYNC_LOST : sy2_q;
        sync_q <= srst ? `SYNC_LOST : ((sy2_q == sy3_q) ? sy3_q : sync_q);
    end

    ////////////////////////////////////////////////////////////////////////
    wire [1:0] where = cfg.ctrl[`C_WHERE];
    wire role_cfg = cfg.ctrl[`C_ROLE];
    wire flow_hit = (cfg.sel_spi[`S_WILD] | (cls_spi == cfg.sel_spi[`F_SSEL]))
                    & (cfg.sel_flow[`S_WILD]
                       | (cls_flow == cfg.sel_flow[`F_FLOW]));
    // Free run or lost sync refuses a stamp request at the entry node.
    wire sync_stamp_ok = (sync_q == `SYNC_LOCKED)
                         | (sync_q == `SYNC_HOLD);
    wire sop_seen = (st_q == ST_IDLE) & in_valid & in_sop;
    wire stamp_go = sop_seen & role_cfg & active_q & flow_hit
                    & sync_stamp_ok;
    wire refuse_set = sop_seen & role_cfg & active_q & flow_hit
                      & !sync_stamp_ok;
    wire adv = (!out_valid_q | out_ready) & (!rpt_valid_q | rpt_ready);
    wire load_hdr = (st_q == ST_EMIT) & adv;
    wire load_pay = (st_q == ST_PASS) & in_valid & adv;
    wire take_col = (st_q == ST_COLLECT) & in_valid;
    wire last_w = (idx_q == `W_TSL);

    // Local stamp point is one setting for the whole domain.
    wire [63:0] ts_pick = (where == `WH_EGR) ? ts_now : ts_loc_q;
    wire [63:0] ts_in = {hdr_q[`W_TSH], hdr_q[`W_TSL]};
    wire [63:0] latency = ts_pick - ts_in;
    wire [30:0] thr_in = hdr_q[`W_THR][`F_THR];
    wire marked = hdr_q[`W_THR][`F_VIOL];
    wire kind_ts = hdr_q[`W_FLOW][`F_KIND] == `KIND_TS;
    wire node_sel = (where != `WH_SPEC)
                    | (hdr_q[`W_PATH][`F_SI] == cfg.ctrl[`C_TSI]);
    wire viol_d = !marked & node_sel & kind_ts
                  & (sync_q == `SYNC_LOCKED) & (thr_in != 31'h0)
                  & (latency > {33'h0, thr_in});

    // Header words built by the entry classifier.
    wire word_t st_base = {2'h0, 1'b0, 1'b0, 6'h0, `BASE_LEN,
                           `MD_TYPE_KPI, cls_next_proto};
    wire word_t st_path = {cls_spi, cls_si};
    wire word_t st_ctx = {`MD_CLASS_KPI, 1'b1, `TYPE_TS_DETECT,
                          1'b0, `CTX_LEN};
    wire word_t st_flow = {cfg.ctrl[`C_KIND], 8'h0, cls_flow};
    wire word_t st_thr = {1'b0, cfg.ctrl[`C_THR_EN]
                          ? cfg.thresh[`F_THR] : 31'h0};

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_q <= ST_IDLE;
            idx_q <= 3'h0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    idx_q <= 3'h0;
                    if (sop_seen) begin
                        st_q <= !role_cfg ? ST_COLLECT :
                                stamp_go ? ST_DECIDE : ST_PASS;
                    end
                end
                ST_COLLECT: begin
                    if (take_col) begin
                        idx_q <= idx_q + 3'h1;
                    end
                    if (take_col & last_w) begin
                        st_q <= ST_DECIDE;
                    end
                end
                ST_DECIDE: begin
                    idx_q <= 3'h0;
                    st_q <= ST_EMIT;
                end
                ST_EMIT: begin
                    if (load_hdr) begin
                        idx_q <= idx_q + 3'h1;
                    end
                    if (load_hdr & last_w) begin
                        st_q <= ST_PASS;
                    end
                end
                ST_PASS: begin
                    if (load_pay & in_eop) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // A marked packet keeps every header bit, so it passes untouched.
    always_ff @(posedge ref_clk) begin
        if (stamp_go) begin
            hdr_q[`W_BASE] <= st_base;
            hdr_q[`W_PATH] <= st_path;
            hdr_q[`W_CTX] <= st_ctx;
            hdr_q[`W_FLOW] <= st_flow;
            hdr_q[`W_THR] <= st_thr;
        end else if (take_col) begin
            hdr_q[idx_q] <= in_data;
        end else if (st_q == ST_DECIDE && role_q) begin
            hdr_q[`W_TSH] <= ts_pick[63:32];
            hdr_q[`W_TSL] <= ts_pick[31:0];
        end else if (st_q == ST_DECIDE && viol_d) begin
            hdr_q[`W_THR][`F_VIOL] <= 1'b1;
            hdr_q[`W_FLOW][`F_VSI] <= hdr_q[`W_PATH][`F_SI];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            role_q <= 1'b0;
            viol_q <= 1'b0;
            hdr_sent_q <= 1'b0;
            proc_q <= 1'b0;
            ts_loc_q <= 64'h0;
        end else if (sop_seen) begin
            role_q <= role_cfg;
            viol_q <= 1'b0;
            hdr_sent_q <= 1'b0;
            proc_q <= 1'b0;
            ts_loc_q <= ts_now;
        end else if (st_q == ST_DECIDE) begin
            viol_q <= !role_q & viol_d;
            hdr_sent_q <= 1'b1;
            proc_q <= !role_q & !marked;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Campaign control; a start write restarts both limits.
    wire lim_pk_hit = (cfg.lim_pkts != 32'h0) & (pkts_q >= cfg.lim_pkts);
    wire lim_tm_hit = (cfg.lim_time != 32'h0) & (time_q >= cfg.lim_time);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            active_q <= 1'b0;
            pkts_q <= 32'h0;
            time_q <= 32'h0;
        end else if (cfg.start) begin
            active_q <= 1'b1;
            pkts_q <= 32'h0;
            time_q <= 32'h0;
        end else begin
            active_q <= active_q & !lim_pk_hit & !lim_tm_hit;
            pkts_q <= pkts_q + {31'h0, stamp_go};
            time_q <= active_q ? time_q + 32'h1 : time_q;
        end
    end

    // A refusal in the clearing cycle still leaves the flag set.
    always_ff @(posedge ref_clk) begin
        refuse_q <= srst ? 1'b0 : (refuse_set | (refuse_q & !cfg.clr_refuse));
        viol_cnt_q <= srst ? 16'h0 : (cfg.start ? 16'h0
                      : viol_cnt_q + {15'h0, (st_q == ST_DECIDE)
                                      & !role_q & viol_d});
    end

    assign cfg.active = active_q;
    assign cfg.refuse = refuse_q;
    assign cfg.sync = sync_q;
    assign cfg.stamp_cnt = pkts_q[15:0];
    assign cfg.viol_cnt = viol_cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // The register slice holds one word; a stalled report port stalls
    // the forward path too, so a header copy is never lost.
    wire word_t out_d = load_hdr ? hdr_q[idx_q] : in_data;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            out_valid_q <= 1'b0;
            out_sop_q <= 1'b0;
            out_eop_q <= 1'b0;
            out_hw_q <= 1'b0;
            out_w_q <= 3'h0;
            out_data_q <= 32'h0;
        end else if (load_hdr | load_pay) begin
            out_valid_q <= 1'b1;
            out_data_q <= out_d;
            out_sop_q <= load_hdr ? (idx_q == `W_BASE)
                         : (in_sop & !hdr_sent_q);
            out_eop_q <= load_pay & in_eop;
            out_hw_q <= load_hdr;
            out_w_q <= idx_q;
        end else if (out_ready) begin
            out_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rpt_valid_q <= 1'b0;
            rpt_last_q <= 1'b0;
            rpt_data_q <= 32'h0;
        end else if (load_hdr & viol_q) begin
            rpt_valid_q <= 1'b1;
            rpt_data_q <= hdr_q[idx_q];
            rpt_last_q <= last_w;
        end else if (rpt_ready) begin
            rpt_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rpt_kind_q <= 8'h0;
            rpt_flags_q <= 4'h0;
        end else if (st_q == ST_DECIDE) begin
            rpt_kind_q <= kind_ts ? `RPT_TS_EXT : `RPT_QOS_EXT;
            rpt_flags_q <= {where != `WH_EGR, where != `WH_ING,
                            sync_q};
        end
    end

    assign in_ready = (st_q == ST_COLLECT) | ((st_q == ST_PASS) & adv)
                      | ((st_q == ST_IDLE) & !in_sop);
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;
    assign out_sop = out_sop_q;
    assign out_eop = out_eop_q;
    assign rpt_valid = rpt_valid_q;
    assign rpt_data = rpt_data_q;
    assign rpt_last = rpt_last_q;
    assign rpt_kind = rpt_kind_q;
    assign rpt_flags = rpt_flags_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    wire st_hdr = out_valid_q & out_hw_q & role_q;

    a_md_type_two: assert property (
        st_hdr && out_w_q == `W_BASE |-> out_data_q[`F_MDTYPE] == 8'h02)
        else $error("stamped header has wrong metadata type");
    a_class_crit: assert property (
        st_hdr && out_w_q == `W_CTX
        |-> out_data_q[`F_CLASS] == 16'h0210 && out_data_q[`F_CRIT])
        else $error("context class or critical bit wrong");
    a_type_msb_zero: assert property (
        st_hdr && out_w_q == `W_CTX |-> !out_data_q[`F_TYPE_MSB])
        else $error("stamp type top bit set");
    a_oam_clear: assert property (
        st_hdr && out_w_q == `W_BASE |-> !out_data_q[`F_OAM])
        else $error("oam bit set on stamped packet");
    a_flow_id_kept: assert property (
        stamp_go ##1 st_q == ST_DECIDE
        |-> hdr_q[`W_FLOW][`F_FLOW] == $past(cls_flow))
        else $error("flow identifier not inserted");
    a_viol_marks_si: assert property (
        st_q == ST_DECIDE && !role_q && viol_d
        |=> hdr_q[`W_THR][`F_VIOL]
            && hdr_q[`W_FLOW][`F_VSI] == hdr_q[`W_PATH][`F_SI])
        else $error("violation not marked with service index");
    a_marked_skip: assert property (
        st_q == ST_DECIDE && marked |=> !viol_q)
        else $error("marked packet processed again");
    a_report_copy: assert property (
        load_hdr && viol_q |=> rpt_valid_q && rpt_data_q == out_data_q)
        else $error("violation header not copied to report");
    a_pay_intact: assert property (
        load_pay |=> out_valid_q && out_data_q == $past(in_data))
        else $error("payload word changed");
    a_pkt_limit: assert property (
        lim_pk_hit && !cfg.start |=> !active_q)
        else $error("stamping continued past packet limit");

    c_stamped: cover property (stamp_go ##[1:20] load_hdr && last_w);
    c_violation: cover property (st_q == ST_DECIDE && viol_d);
    c_marked_pass: cover property (st_q == ST_DECIDE && marked);
    c_refused: cover property (refuse_set);
endmodule

// ===== node_sink.sv
`timescale 1ns/1ps
module node_sink (
    input wire logic ref_clk,
    input wire logic stall,
    input wire logic out_valid,
    input wire nsh_kpi_pkg::word_t out_data,
    output logic out_ready,
    input wire logic rpt_valid,
    input wire nsh_kpi_pkg::word_t rpt_data,
    output logic rpt_ready
);
    import nsh_kpi_pkg::*;
    word_t oq[$];
    word_t rq[$];
    logic tgl = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // A stalling neighbour takes a word only every other cycle, as a busy node would.
    assign out_ready = !stall || tgl;
    assign rpt_ready = !stall || tgl;
    always @(posedge ref_clk) begin
        tgl <= ~tgl;
        if (out_valid && out_ready) begin
            oq.push_back(out_data);
        end
        if (rpt_valid && rpt_ready) begin
            rq.push_back(rpt_data);
        end
    end
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
`include "nsh_kpi_defs.svh"
module tb_top;
    import nsh_kpi_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    word_t avs_writedata = 32'h0;
    word_t avs_readdata;
    logic avs_waitrequest;
    logic in_valid = 1'b0;
    logic in_ready;
    word_t in_data = 32'h0;
    logic in_sop = 1'b0;
    logic in_eop = 1'b0;
    logic [63:0] ts_now = 64'h0000_0010_0000_5000;
    sync_t sync_state = 2'h0;
    logic out_valid, out_ready, out_sop, out_eop, rpt_valid, rpt_ready;
    logic rpt_last, stall = 1'b1;
    word_t out_data, rpt_data, q;
    logic [7:0] rpt_kind;
    logic [3:0] rpt_flags;
    int compares = 0;
    int miscompares = 0;
    int cyc = 0;
    int sops = 0, eops = 0, lasts = 0;
    always #4 ref_clk = ~ref_clk;
    nsh_kpi_stamp_detector uut (.ref_clk(ref_clk), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data), .in_sop(in_sop),
        .in_eop(in_eop), .cls_spi(24'h0ABCDE), .cls_si(8'hFF),
        .cls_flow(16'h1234), .cls_next_proto(8'h01), .ts_now(ts_now),
        .sync_state(sync_state), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .out_sop(out_sop),
        .out_eop(out_eop), .rpt_valid(rpt_valid), .rpt_ready(rpt_ready),
        .rpt_data(rpt_data), .rpt_last(rpt_last), .rpt_kind(rpt_kind),
        .rpt_flags(rpt_flags));
    node_sink snk (.ref_clk(ref_clk), .stall(stall), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready), .rpt_valid(rpt_valid),
        .rpt_data(rpt_data), .rpt_ready(rpt_ready));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input word_t s, input word_t e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp=%h seen=%h", nm, e, s);
        end
    endtask
    task automatic bus(input logic we, input logic [4:0] a, input word_t d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= we;
        avs_read <= !we;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Valid is left high between words so no signal is driven twice a step.
    task automatic push(input word_t d, input logic s, input logic e);
        in_data <= d;
        in_sop <= s;
        in_eop <= e;
        in_valid <= 1'b1;
        do @(posedge ref_clk); while (in_ready !== 1'b1);
    endtask
    task automatic send(input word_t w[$]);
        foreach (w[i]) push(w[i], i == 0, i == w.size() - 1);
        in_valid <= 1'b0;
        for (int k = 0; k < 300 && snk.oq.size() < w.size(); k++) begin
            @(posedge ref_clk);
        end
        repeat (20) @(posedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_stamp();
        bus(1'b1, `A_SEL_SPI, 32'h8000_0000);
        bus(1'b1, `A_SEL_FLOW, 32'h8000_0000);
        bus(1'b1, `A_THRESH, 32'h0000_0064);
        bus(1'b1, `A_CTRL, 32'h0000_0113);
        send('{32'hA5A5_0001, 32'hA5A5_0002});
        chk("mdtype", snk.oq[0][15:8], `MD_TYPE_KPI);
        chk("oam", snk.oq[0][`F_OAM], 0);
        chk("class", snk.oq[2][31:16], `MD_CLASS_KPI);
        chk("crit", snk.oq[2][`F_CRIT], 1);
        chk("type", snk.oq[2][14:8], `TYPE_TS_DETECT);
        chk("flow", snk.oq[3][15:0], 32'h1234);
        chk("kind", snk.oq[3][31:24], `KIND_TS);
        chk("thr", snk.oq[4], 32'h0000_0064);
        chk("ts_hi", snk.oq[5], ts_now[63:32]);
        chk("ts_lo", snk.oq[6], ts_now[31:0]);
        chk("pay0", snk.oq[7], 32'hA5A5_0001);
        chk("pay1", snk.oq[8], 32'hA5A5_0002);
        chk("sop_n", sops, 1);
        chk("eop_n", eops, 1);
        bus(1'b0, `A_COUNT, 32'h0);
        chk("stamped", q[15:0], 1);
    endtask
    task automatic t_check();
        word_t h[$];
        h = '{32'h0007_0201, 32'h0ABC_DEFE, 32'h0210_8104, 32'h0100_1234,
            32'h0000_0064, 32'h0000_0010, 32'h0000_4000, 32'h0000_BEEF};
        snk.oq.delete();
        bus(1'b1, `A_CTRL, 32'h0000_0102);
        send(h);
        chk("vsi", snk.oq[3][23:16], 32'hFE);
        chk("viol", snk.oq[4], 32'h8000_0064);
        chk("pay", snk.oq[7], 32'h0000_BEEF);
        chk("rpt_n", snk.rq.size(), 7);
        chk("rpt_path", snk.rq[1], h[1]);
        chk("rpt_kind", rpt_kind, `RPT_TS_EXT);
        chk("rpt_sync", rpt_flags[1:0], `SYNC_LOCKED);
        chk("rpt_dir", rpt_flags[3:2], 2'h2);
        chk("rpt_last", lasts, 1);
        chk("sop_n2", sops, 2);
        chk("eop_n2", eops, 2);
        h[4] = 32'h8000_0064;
        snk.oq.delete();
        send(h);
        chk("again", snk.oq[3], h[3]);
        chk("rpt_n2", snk.rq.size(), 7);
    endtask
    task automatic t_sync();
        sync_state <= `SYNC_LOST;
        repeat (6) @(posedge ref_clk);
        bus(1'b0, `A_STATUS, 32'h0);
        chk("sync", q[3:2], `SYNC_LOST);
        bus(1'b1, `A_CTRL, 32'h0000_0113);
        snk.oq.delete();
        send('{32'hA5A5_0003});
        chk("unstamped", snk.oq[0], 32'hA5A5_0003);
        bus(1'b0, `A_STATUS, 32'h0);
        chk("refused", q[1], 1);
        bus(1'b1, `A_STATUS, 32'h0000_0002);
        bus(1'b0, `A_STATUS, 32'h0);
        chk("refuse_clr", q[1], 0);
    endtask
    // One packet of budget: the second packet of the campaign goes bare.
    task automatic t_limit();
        sync_state <= `SYNC_LOCKED;
        repeat (6) @(posedge ref_clk);
        bus(1'b1, `A_LIM_PKTS, 32'h0000_0001);
        bus(1'b1, `A_SEL_FLOW, 32'h0000_1234);
        bus(1'b1, `A_CTRL, 32'h0000_0113);
        snk.oq.delete();
        send('{32'hA5A5_0004});
        chk("exact", snk.oq.size(), 8);
        bus(1'b0, `A_STATUS, 32'h0);
        chk("active", q[0], 0);
        snk.oq.delete();
        send('{32'hA5A5_0005});
        chk("stopped", snk.oq[0], 32'hA5A5_0005);
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        cyc++;
        sops += int'(out_valid && out_ready && out_sop);
        eops += int'(out_valid && out_ready && out_eop);
        lasts += int'(rpt_valid && rpt_ready && rpt_last);
        if (cyc == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        t_stamp();
        t_check();
        t_sync();
        t_limit();
        tally_and_finish();
    end
endmodule
